// [logic/nfh_regs.svh]
// opcodes, pin cycle timing and limits for the nand host sequencer
`ifndef NFH_REGS_SVH
`define NFH_REGS_SVH
`define NFH_OP_READ1 8'h00
`define NFH_OP_READ2 8'h30
`define NFH_OP_PROG1 8'h80
`define NFH_OP_PROG2 8'h10
`define NFH_OP_ERASE1 8'h60
`define NFH_OP_ERASE2 8'hd0
`define NFH_OP_RESET 8'hff
`define NFH_OP_STATUS 8'h70
`define NFH_ERASED 8'hff
`define NFH_ROW3 8'h00
`define NFH_NOP_MAX 3'h4
`define NFH_MARK_COL 12'h800
`define NFH_ONE_BYTE 12'h001
`define NFH_ADDR_LAST 12'h004
`define NFH_ERASE_FIRST 12'h002
`define NFH_BLK_HI 15
`define NFH_BLK_LO 6
`define NFH_PG_ZERO 5'h00
`define NFH_LAST_BLK 10'h3ff
`define NFH_SAFE_BLK 10'h000
`define NFH_WE_LO_BEG 3'h2
`define NFH_WE_LO_END 3'h4
`define NFH_WR_END 3'h5
`define NFH_RE_LO_END 3'h5
`define NFH_RD_END 3'h7
`define NFH_CLK_NS 10
`define NFH_T_GAP_NS 100
`define NFH_GAP_CYC ((`NFH_T_GAP_NS + `NFH_CLK_NS - 1) / `NFH_CLK_NS)
`define NFH_T_R_US 40
`define NFH_T_RST_US 5
`define NFH_T_PROG_US 750
`define NFH_T_BERS_MS 10
`define NFH_R_CYC (`NFH_T_R_US * 1000 / `NFH_CLK_NS)
`define NFH_RST_CYC (`NFH_T_RST_US * 1000 / `NFH_CLK_NS)
`define NFH_PROG_CYC (`NFH_T_PROG_US * 1000 / `NFH_CLK_NS)
`define NFH_BERS_CYC (`NFH_T_BERS_MS * 1000000 / `NFH_CLK_NS)
`endif

// [logic/nfh_pkg.sv]
// types shared by the nand host sequencer
package nfh_pkg;
  typedef enum logic [2:0] {
    nfh_read, nfh_prog, nfh_erase, nfh_reset, nfh_status
  } nfh_op_t;
  typedef enum logic [3:0] {
    s_idle, s_pre, s_cmd1, s_addr, s_gapw, s_din, s_cmd2, s_wait,
    s_stcmd, s_gapr, s_dout, s_fin
  } nfh_state_t;
  typedef struct packed {
    logic [2:0] op;
    logic [15:0] row;
    logic [11:0] col;
    logic [11:0] len;
  } nfh_req_t;
  typedef struct packed {
    logic [7:0] status;
    logic err_op;
    logic err_bad;
    logic err_nop;
    logic err_tmo;
  } nfh_resp_t;
  typedef struct packed {
    logic cle;
    logic ale;
    logic ce_n;
    logic we_n;
    logic output_strobe_n;
    logic wp_n;
  } nfh_pins_t;
endpackage

// [logic/nfh_ctrl.sv]
// nand flash host sequencer with factory bad block scan
`timescale 1ns/100ps
`include "nfh_regs.svh"
// Functional notes
// - at most four partial programs per page; counted only while the same page is programmed again in a row
// - scan marking into table, never erase it
// - no program or erase to marked blocks
// - invalid blocks are never accessed; the scan still reads every block, and block 0 is never marked
// - latch lines change only while write strobe high
// - only defined command codes issued
module nfh_ctrl #(
  parameter int unsigned PROG_TMO = `NFH_PROG_CYC,
  parameter int unsigned BERS_TMO = `NFH_BERS_CYC
) (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_req_valid,
  input wire nfh_pkg::nfh_req_t i_req,
  output logic o_req_ready,
  input wire logic [7:0] i_wdata,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [7:0] o_rdata,
  output logic o_rvalid,
  output logic o_done,
  output nfh_pkg::nfh_resp_t o_resp,
  output logic o_scan_done,
  output nfh_pkg::nfh_pins_t o_pins,
  output logic [7:0] o_io,
  output logic o_io_oe_n,
  input wire logic [7:0] i_io,
  input wire logic i_ready_busy_n
);
  import nfh_pkg::*;

  localparam logic [3:0] GAP = 4'(`NFH_GAP_CYC);
  localparam logic [19:0] R_LIM = 20'(`NFH_R_CYC);
  localparam logic [19:0] RST_LIM = 20'(`NFH_RST_CYC);
  localparam logic [19:0] PROG_LIM = 20'(PROG_TMO);
  localparam logic [19:0] BERS_LIM = 20'(BERS_TMO);

  nfh_state_t state, next_state;
  logic [2:0] tick, next_tick;
  logic [11:0] idx, next_idx;
  logic [3:0] gap, next_gap;
  logic [19:0] tmo, next_tmo;
  logic next_wready;
  nfh_req_t cur;
  logic [7:0] dbuf;
  logic scan;
  logic [9:0] scan_blk;
  logic scan_pg;
  logic [1023:0] bbt;
  logic [15:0] last_row;
  logic [2:0] pcount;
  logic [7:0] io_s1, io_s2;
  logic rb_s1, rb_s2;

  // pin synchronisers; first stage is read by the second only
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      io_s1 <= 8'h00;
      io_s2 <= 8'h00;
      rb_s1 <= 1'b0;
      rb_s2 <= 1'b0;
    end else begin
      io_s1 <= i_io;
      io_s2 <= io_s1;
      rb_s1 <= i_ready_busy_n;
      rb_s2 <= rb_s1;
    end
  end

  // cycle type decode
  wire is_cmd = (state == s_cmd1) || (state == s_cmd2) || (state == s_stcmd);
  wire in_wr = is_cmd || (state == s_addr) || ((state == s_din) && !o_wready);
  wire in_rd = (state == s_dout);
  wire wr_end = in_wr && (tick == `NFH_WR_END);
  wire rd_end = in_rd && (tick == `NFH_RD_END);
  wire cur_rd = (cur.op == nfh_read);
  wire cur_pg = (cur.op == nfh_prog);
  wire cur_er = (cur.op == nfh_erase);
  wire cur_rst = (cur.op == nfh_reset);
  wire [11:0] dlast = (cur.len == 12'h000) ? 12'h000 : cur.len - 12'h001;
  wire [11:0] olast = cur_rd ? dlast : 12'h000;
  wire gap_zero = (gap == 4'h0);
  wire [19:0] tmo_lim = cur_rd ? R_LIM : cur_pg ? PROG_LIM :
                        cur_er ? BERS_LIM : RST_LIM;
  wire rb_tmo = (tmo == tmo_lim);
  wire [9:0] cur_blk = cur.row[`NFH_BLK_HI:`NFH_BLK_LO];

  // bytes put on the port; cycle index picks the address byte
  wire [7:0] addr_byte = (idx[2:0] == 3'h0) ? cur.col[7:0] :
                         (idx[2:0] == 3'h1) ? {4'h0, cur.col[11:8]} :
                         (idx[2:0] == 3'h2) ? cur.row[7:0] :
                         (idx[2:0] == 3'h3) ? cur.row[15:8] : `NFH_ROW3;
  wire [7:0] cmd1 = cur_rd ? `NFH_OP_READ1 : cur_pg ? `NFH_OP_PROG1 :
                    cur_er ? `NFH_OP_ERASE1 : cur_rst ? `NFH_OP_RESET :
                    `NFH_OP_STATUS;
  wire [7:0] cmd2 = cur_rd ? `NFH_OP_READ2 : cur_pg ? `NFH_OP_PROG2 :
                    `NFH_OP_ERASE2;
  wire [7:0] cmd_byte = (state == s_stcmd) ? `NFH_OP_STATUS :
                        (state == s_cmd2) ? cmd2 : cmd1;
  wire [7:0] out_byte = is_cmd ? cmd_byte :
                        (state == s_addr) ? addr_byte : dbuf;

  // request screening against op set, bad blocks and program count
  wire [9:0] req_blk = i_req.row[`NFH_BLK_HI:`NFH_BLK_LO];
  wire req_pg = (i_req.op == nfh_prog);
  wire req_er = (i_req.op == nfh_erase);
  wire op_ok = (i_req.op == nfh_read) || req_pg || req_er ||
               (i_req.op == nfh_reset) || (i_req.op == nfh_status);
  wire needs_good = (i_req.op == nfh_read) || req_pg || req_er;
  wire req_bad = needs_good && bbt[req_blk];
  wire row_same = (i_req.row == last_row);
  // fifth program in a row to one page refused
  wire req_nop = req_pg && row_same && (pcount >= `NFH_NOP_MAX);
  wire take = (state == s_idle) && !scan && i_req_valid && o_req_ready;
  wire refuse = !op_ok || req_bad || req_nop;
  wire accept = take && !refuse;
  // read column 2048 of pages 0 and 1
  wire [15:0] scan_row = {scan_blk, `NFH_PG_ZERO, scan_pg};
  wire scan_last = (scan_blk == `NFH_LAST_BLK) && scan_pg;
  // anything but all ones marks the block, block 0 excepted
  wire marked = (io_s2 != `NFH_ERASED);
  wire mark_bad = scan && rd_end && marked && (cur_blk != `NFH_SAFE_BLK);

  // sequencer: command, address, data, busy wait, status
  always_comb begin
    next_state = state;
    next_tick = tick;
    next_idx = idx;
    next_gap = gap;
    next_tmo = tmo;
    next_wready = o_wready;
    case (state)
      s_idle: begin
        if (scan || accept) begin
          next_state = s_pre;
          next_gap = GAP;
        end
      end
      s_pre: begin
        if (gap_zero) begin
          next_state = s_cmd1;
          next_tick = 3'h0;
        end else begin
          next_gap = gap - 4'h1;
        end
      end
      s_cmd1: begin
        next_tick = tick + 3'h1;
        if (wr_end) begin
          next_tick = 3'h0;
          next_idx = cur_er ? `NFH_ERASE_FIRST : 12'h000;
          next_gap = GAP;
          next_tmo = 20'h00000;
          next_state = cur_rst ? s_wait :
                       (cur.op == nfh_status) ? s_gapr : s_addr;
        end
      end
      s_addr: begin
        next_tick = tick + 3'h1;
        if (wr_end) begin
          next_tick = 3'h0;
          next_idx = idx + 12'h001;
          // five address cycles, three for erase
          if (idx == `NFH_ADDR_LAST) begin
            next_idx = 12'h000;
            next_gap = GAP;
            next_state = (cur_pg && (cur.len != 12'h000)) ? s_gapw : s_cmd2;
          end
        end
      end
      s_gapw: begin
        next_gap = gap - 4'h1;
        if (gap_zero) begin
          next_state = s_din;
          next_wready = 1'b1;
        end
      end
      s_din: begin
        if (o_wready) begin
          next_wready = !i_wvalid;
        end else if (wr_end) begin
          next_tick = 3'h0;
          next_idx = idx + 12'h001;
          next_wready = (idx != dlast);
          next_state = (idx == dlast) ? s_cmd2 : s_din;
        end else begin
          next_tick = tick + 3'h1;
        end
      end
      s_cmd2: begin
        next_tick = tick + 3'h1;
        if (wr_end) begin
          next_tick = 3'h0;
          next_gap = GAP;
          next_tmo = 20'h00000;
          next_state = s_wait;
        end
      end
      s_wait: begin
        if (!gap_zero) begin
          next_gap = gap - 4'h1;
        end else if (rb_s2) begin
          next_gap = GAP;
          next_idx = 12'h000;
          next_state = cur_rst ? s_fin : cur_rd ? s_gapr : s_stcmd;
        end else if (rb_tmo) begin
          // busy past the limit ends the operation
          next_state = s_fin;
        end else begin
          next_tmo = tmo + 20'h00001;
        end
      end
      s_stcmd: begin
        next_tick = tick + 3'h1;
        if (wr_end) begin
          next_tick = 3'h0;
          next_gap = GAP;
          next_state = s_gapr;
        end
      end
      s_gapr: begin
        next_gap = gap - 4'h1;
        if (gap_zero) begin
          next_state = s_dout;
          next_tick = 3'h0;
          next_idx = 12'h000;
        end
      end
      s_dout: begin
        next_tick = tick + 3'h1;
        if (rd_end) begin
          next_tick = 3'h0;
          next_idx = idx + 12'h001;
          next_state = (idx == olast) ? s_fin : s_dout;
        end
      end
      s_fin: next_state = s_idle;
      default: next_state = s_idle;
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      state <= s_idle;
      tick <= 3'h0;
      idx <= 12'h000;
      gap <= 4'h0;
      tmo <= 20'h00000;
      o_wready <= 1'b0;
    end else begin
      state <= next_state;
      tick <= next_tick;
      idx <= next_idx;
      gap <= next_gap;
      tmo <= next_tmo;
      o_wready <= next_wready;
    end
  end

  // pins lag the decode by one cycle, keeping the relative timing
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_pins <= '{cle: 1'b0, ale: 1'b0, ce_n: 1'b1, we_n: 1'b1,
                  output_strobe_n: 1'b1, wp_n: 1'b0};
      o_io <= 8'h00;
      o_io_oe_n <= 1'b1;
      o_req_ready <= 1'b0;
    end else begin
      // latch pair marks the cycle type
      o_pins.cle <= is_cmd;
      o_pins.ale <= (state == s_addr);
      o_pins.ce_n <= (state == s_idle);
      o_pins.we_n <= !(in_wr && (tick >= `NFH_WE_LO_BEG) &&
                       (tick <= `NFH_WE_LO_END));
      o_pins.output_strobe_n <= !(in_rd && (tick <= `NFH_RE_LO_END));
      // write lock released only for program and erase
      // lock closes with the last cycle, so idle never sees it open
      o_pins.wp_n <= (state != s_idle) && (next_state != s_idle) &&
                     (cur_pg || cur_er);
      o_io <= out_byte;
      o_io_oe_n <= !(in_wr || (state == s_din));
      o_req_ready <= (next_state == s_idle) && !scan;
    end
  end

  // request capture, results and scan progress
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      cur <= '0;
      dbuf <= 8'h00;
      o_rdata <= 8'h00;
      o_rvalid <= 1'b0;
      o_done <= 1'b0;
      o_resp <= '0;
      scan <= 1'b1;
      scan_blk <= 10'h000;
      scan_pg <= 1'b0;
      o_scan_done <= 1'b0;
    end else begin
      o_rvalid <= rd_end && cur_rd && !scan;
      o_done <= (take && refuse) || ((state == s_fin) && !scan);
      if ((state == s_idle) && scan) begin
        cur <= '{op: nfh_read, row: scan_row, col: `NFH_MARK_COL,
                 len: `NFH_ONE_BYTE};
      end else if (accept) begin
        cur <= i_req;
      end
      if (take) begin
        o_resp <= '{status: 8'h00, err_op: !op_ok, err_bad: req_bad,
                    err_nop: req_nop, err_tmo: 1'b0};
      end else if ((state == s_wait) && gap_zero && !rb_s2 && rb_tmo) begin
        o_resp.err_tmo <= !scan;
      end else if (rd_end && !cur_rd) begin
        o_resp.status <= io_s2;
      end
      if (o_wready && i_wvalid) begin
        dbuf <= i_wdata;
      end
      if (rd_end && cur_rd) begin
        o_rdata <= io_s2;
      end
      // original marking kept once, scan then stops
      if ((state == s_fin) && scan) begin
        scan_pg <= !scan_pg;
        scan_blk <= scan_pg ? scan_blk + 10'h001 : scan_blk;
        scan <= !scan_last;
        o_scan_done <= scan_last;
      end
    end
  end

  // invalid block table and partial program count
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      bbt <= '0;
      last_row <= 16'h0000;
      pcount <= 3'h0;
    end else begin
      if (mark_bad) begin
        bbt[cur_blk] <= 1'b1;
      end
      // count programs to the open page
      if (accept && req_pg) begin
        last_row <= i_req.row;
        pcount <= row_same ? pcount + 3'h1 : 3'h1;
      end else if (accept && req_er &&
                   (last_row[`NFH_BLK_HI:`NFH_BLK_LO] == req_blk)) begin
        pcount <= 3'h0;
      end
    end
  end
endmodule // nfh_ctrl

// [test/nfh_ctrl_chk.sv]
// assertions on the nand host sequencer ports
`timescale 1ns/100ps
module nfh_ctrl_chk (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_req_valid,
  input wire nfh_pkg::nfh_req_t i_req,
  input wire logic o_req_ready,
  input wire logic i_wvalid,
  input wire logic o_wready,
  input wire logic o_done,
  input wire nfh_pkg::nfh_resp_t o_resp,
  input wire logic o_scan_done,
  input wire nfh_pkg::nfh_pins_t o_pins,
  input wire logic o_io_oe_n
);
  import nfh_pkg::*;
  // one clock domain, so one default clocking and reset
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  // an illegal opcode taken from the request port
  wire bad_take = i_req_valid && o_req_ready && (i_req.op > 3'h4);
  latch_hold_a: assert property (
    !o_pins.we_n && !$past(o_pins.we_n) |->
    $stable({o_pins.cle, o_pins.ale, o_pins.ce_n}))
    else $error("latch lines moved inside a write strobe");
  write_sel_a: assert property (
    !o_pins.we_n |-> !o_pins.ce_n && !o_io_oe_n && !(o_pins.cle && o_pins.ale))
    else $error("write strobe without a valid write cycle");
  read_sel_a: assert property (
    !o_pins.output_strobe_n |-> !o_pins.ce_n && o_io_oe_n && o_pins.we_n &&
    !o_pins.cle && !o_pins.ale)
    else $error("read strobe without a valid read cycle");
  byte_take_a: assert property (
    o_wready && i_wvalid |=> !o_wready)
    else $error("write byte ready held after a take");
  lock_idle_a: assert property (
    o_req_ready |-> !o_pins.wp_n)
    else $error("write lock released while idle");
  scan_first_a: assert property (
    o_req_ready |-> o_scan_done)
    else $error("request accepted before the block scan");
  bad_op_a: assert property (
    bad_take |-> ##[1:2] (o_done && o_resp.err_op))
    else $error("illegal opcode not refused");
  bad_quiet_a: assert property (
    bad_take |=> o_pins.ce_n [*3])
    else $error("pins active for a refused opcode");
endmodule // nfh_ctrl_chk

bind nfh_ctrl nfh_ctrl_chk u_nfh_ctrl_chk (.i_clk_sys(i_clk_sys),
  .i_resetn(i_resetn), .i_req_valid(i_req_valid), .i_req(i_req),
  .o_req_ready(o_req_ready), .i_wvalid(i_wvalid), .o_wready(o_wready),
  .o_done(o_done), .o_resp(o_resp), .o_scan_done(o_scan_done),
  .o_pins(o_pins), .o_io_oe_n(o_io_oe_n));

// [test/nfh_flash_model.sv]
// behavioural nand flash die driven by the host pins
`timescale 1ns/100ps
module nfh_flash_model #(
  parameter int T_R_NS = 200,
  parameter int T_RST_NS = 300,
  parameter int T_PRG_NS = 400,
  parameter logic [9:0] BAD_BLK = 10'h005,
  parameter logic [7:0] STATUS = 8'he0
) (
  input wire nfh_pkg::nfh_pins_t i_pins,
  input wire logic [7:0] i_io,
  output logic [7:0] o_io,
  output logic o_ready_busy_n
);
  import nfh_pkg::*;
  logic [7:0] mem [int];
  logic [7:0] a [0:4];
  logic [7:0] cmd, dout;
  logic [15:0] row, last_row;
  int na, ptr, partial_program_limit, nop_over, bad_hit, stretch, ks[$];
  task automatic busy(int t);
    o_ready_busy_n = 1'b0;
    #(t);
    o_ready_busy_n = 1'b1;
  endtask
  // erased array, one marked block, never block 0
  initial begin
    o_ready_busy_n = 1'b1;
    dout = 8'h00; cmd = 8'h00; na = 0; ptr = 0;
    partial_program_limit = 0; nop_over = 0; bad_hit = 0; last_row = '1;
    stretch = 0;
    mem[{BAD_BLK, 6'h01, 12'h800}] = 8'h00;
  end
  // released bus shows the inverted last byte, never the byte itself
  assign o_io = (!i_pins.ce_n && !i_pins.output_strobe_n) ? dout : ~dout;
  always @(negedge i_pins.output_strobe_n) if (!i_pins.ce_n) begin
    dout = (cmd == 8'h70) ? STATUS :
      (mem.exists({row, ptr[11:0]}) ? mem[{row, ptr[11:0]}] : 8'hff);
    ptr++;
  end
  // write cycle decode, five address cycles, three for erase
  always @(posedge i_pins.we_n) if (!i_pins.ce_n) begin
    if (i_pins.cle) begin
      cmd = i_io;
      na = 0;
      case (i_io)
        8'h30: busy(T_R_NS);
        8'hff: busy(T_RST_NS);
        8'h10: if (i_pins.wp_n) begin
          partial_program_limit = (row == last_row) ? partial_program_limit + 1 : 1;
          last_row = row;
          if (partial_program_limit > 4) nop_over++;
          if (row[15:6] == BAD_BLK) bad_hit++;
          busy(T_PRG_NS);
        end
        8'hd0: if (i_pins.wp_n) begin
          if (row[15:6] == BAD_BLK) bad_hit++;
          ks.delete();
          foreach (mem[k]) if (k[27:18] == row[15:6]) ks.push_back(k);
          foreach (ks[i]) mem.delete(ks[i]);
          last_row = '1;
          // stretch lets the bench push erase past the host limit
          busy(T_PRG_NS + stretch);
        end
        default: ;
      endcase
    end else if (i_pins.ale) begin
      if (na < 5) a[na] = i_io;
      na++;
      if (cmd == 8'h60 && na == 3) row = {a[1], a[0]};
      if (na == 5) begin
        row = {a[3], a[2]};
        ptr = {20'h0, a[1][3:0], a[0]};
      end
    end else if (cmd == 8'h80) begin
      mem[{row, ptr[11:0]}] = i_io;
      ptr++;
    end
  end
endmodule // nfh_flash_model

// [test/tb_nfh_ctrl.sv]
// self-checking bench for the nand host sequencer
`timescale 1ns/100ps
module tb_nfh_ctrl;
  import nfh_pkg::*;
  localparam logic [7:0] STATUS = 8'he0;
  localparam logic [15:0] ROW = {10'h002, 6'h03};
  logic i_clk_sys, i_resetn, i_req_valid, i_wvalid, o_req_ready, o_wready;
  logic o_rvalid, o_done, o_scan_done, oe_n, rb_n;
  logic [7:0] i_wdata, o_rdata, io_h, io_m, bus;
  logic [7:0] rq[$], wq[$];
  nfh_req_t i_req;
  nfh_resp_t got, o_resp;
  nfh_pins_t pins;
  int num_errors = 0;
  int n_checks = 0;
  // wire level: host drives when its enable is low
  assign bus = !oe_n ? io_h : io_m;
  nfh_ctrl #(.PROG_TMO(200), .BERS_TMO(200)) u_nfh_ctrl (
    .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_req_valid(i_req_valid),
    .i_req(i_req), .o_req_ready(o_req_ready), .i_wdata(i_wdata),
    .i_wvalid(i_wvalid), .o_wready(o_wready), .o_rdata(o_rdata),
    .o_rvalid(o_rvalid), .o_done(o_done), .o_resp(o_resp),
    .o_scan_done(o_scan_done), .o_pins(pins), .o_io(io_h), .o_io_oe_n(oe_n),
    .i_io(bus), .i_ready_busy_n(rb_n));
  nfh_flash_model u_nfh_flash_model (.i_pins(pins), .i_io(bus),
    .o_io(io_m), .o_ready_busy_n(rb_n));
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // one request, feeding write bytes and gathering read bytes
  task automatic run(logic [2:0] op, logic [15:0] r, logic [11:0] c,
                     logic [11:0] len);
    int n;
    logic pr, pw;
    // one edge passes so valid never toggles twice in one step
    @(negedge i_clk_sys);
    i_req = '{op, r, c, len};
    rq.delete();
    pr = o_req_ready;
    pw = 1'b0;
    i_req_valid = 1'b1;
    for (n = 0; n < 30000; n++) begin
      @(negedge i_clk_sys);
      if (i_req_valid && pr) i_req_valid = 1'b0;
      if (i_wvalid && pw) void'(wq.pop_front());
      if (o_rvalid) rq.push_back(o_rdata);
      pr = o_req_ready;
      pw = o_wready;
      i_wvalid = (wq.size() != 0);
      if (wq.size() != 0) i_wdata = wq[0];
      if (o_done) break;
    end
    got = o_resp;
    if (n >= 30000) check("done seen", 0, 1);
  endtask
  task automatic t_reset();
    int n;
    repeat (2) @(negedge i_clk_sys);
    check("standby pins", {pins.ce_n, pins.we_n, pins.output_strobe_n,
      pins.wp_n, oe_n}, 5'b11101);
    i_resetn = 1'b1;
    for (n = 0; n < 450000 && o_scan_done !== 1'b1; n++) @(negedge i_clk_sys);
    repeat (2) @(negedge i_clk_sys);
    check("scan done", o_scan_done, 1);
    check("ready after scan", o_req_ready, 1);
    $display("test reset done");
  endtask
  task automatic t_erased();
    run(3'h0, {10'h000, 6'h00}, 12'h000, 12'h003);
    check("read errors", got[3:0], 4'h0);
    check("read count", rq.size(), 3);
    foreach (rq[i]) check("erased byte", rq[i], 8'hff);
    run(3'h0, {10'h003, 6'h01}, 12'h800, 12'h001);
    check("mark byte", rq[0], 8'hff);
    $display("test erased done");
  endtask
  task automatic t_bad();
    for (int op = 0; op < 3; op++) begin
      run(op[2:0], {10'h005, 6'h00}, 12'h000, 12'h001);
      check("bad block refusal", got[3:0], 4'h4);
      check("bad block data", rq.size(), 0);
    end
    check("mark untouched", u_nfh_flash_model.bad_hit, 0);
    $display("test bad block done");
  endtask
  task automatic t_prog();
    wq = '{8'ha5, 8'h3c};
    run(3'h1, ROW, 12'h010, 12'h002);
    check("program resp", got, {STATUS, 4'h0});
    run(3'h0, ROW, 12'h010, 12'h002);
    check("readback", {rq[0], rq[1]}, 16'ha53c);
    for (int i = 0; i < 3; i++) begin
      run(3'h1, ROW, 12'h000, 12'h000);
      check("partial ok", got[3:0], 4'h0);
    end
    run(3'h1, ROW, 12'h000, 12'h000);
    check("fifth partial", got[3:0], 4'h2);
    run(3'h2, ROW, 12'h000, 12'h000);
    check("erase resp", got, {STATUS, 4'h0});
    run(3'h0, ROW, 12'h010, 12'h001);
    check("erased again", rq[0], 8'hff);
    run(3'h1, ROW, 12'h000, 12'h000);
    check("count cleared", got[3:0], 4'h0);
    check("limit kept", u_nfh_flash_model.nop_over, 0);
    $display("test program done");
  endtask
  task automatic t_tmo();
    u_nfh_flash_model.stretch = 3000;
    run(3'h2, ROW, 12'h000, 12'h000);
    check("busy timeout", got[3:0], 4'h1);
    // the die is still busy, so wait before the next command
    wait (rb_n === 1'b1);
    @(negedge i_clk_sys);
    u_nfh_flash_model.stretch = 0;
    $display("test timeout done");
  endtask
  task automatic t_misc();
    run(3'h3, 16'h0000, 12'h000, 12'h000);
    check("reset resp", got[3:0], 4'h0);
    run(3'h4, 16'h0000, 12'h000, 12'h000);
    check("status resp", got, {STATUS, 4'h0});
    for (int op = 5; op < 8; op++) begin
      run(op[2:0], 16'h0000, 12'h000, 12'h000);
      check("illegal op", got[3:0], 4'h8);
    end
    $display("test command set done");
  endtask
  // 100 MHz system clock
  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end
  // scan alone is long, so the limit is generous
  initial begin
    #(5_000_000);
    num_errors++;
    tally_and_finish();
  end
  initial begin
    i_resetn = 1'b0;
    i_req_valid = 1'b0;
    i_req = '0;
    i_wdata = 8'h00;
    i_wvalid = 1'b0;
    t_reset();
    t_erased();
    t_bad();
    t_prog();
    t_tmo();
    t_misc();
    tally_and_finish();
  end
endmodule // tb_nfh_ctrl
